// ### logic/tdcq_defs.vh
// Purpose: Register offsets, field positions, reset values and timing for the compare qualifier.
// Assumes: Avalon-MM word addressing of 32-bit registers.
// Notes:   Definitions only.
`ifndef TDCQ_DEFS_VH
`define TDCQ_DEFS_VH

`define TDCQ_ADDR_W          4
`define TDCQ_REG_SEL_AH      4'h0
`define TDCQ_REG_SEL_AL      4'h1
`define TDCQ_REG_SEL_BH      4'h2
`define TDCQ_REG_SEL_BL      4'h3
`define TDCQ_REG_QUAL        4'h4
`define TDCQ_REG_ACTION      4'h5
`define TDCQ_REG_FILTER      4'h6
`define TDCQ_REG_WINDOW      4'h7
`define TDCQ_REG_PERIOD      4'h8
`define TDCQ_REG_STATUS      4'h9
`define TDCQ_REG_CLEAR       4'hA

`define TDCQ_SEL_RESET       8'h00
`define TDCQ_QUAL_RESET      12'h000
`define TDCQ_PERIOD_RESET    16'h03E7
`define TDCQ_QCODE_W         3

`define TDCQ_ACT_NONE        2'h0
`define TDCQ_ACT_CBC         2'h1
`define TDCQ_ACT_OST         2'h2
`define TDCQ_ACT_DIRECT      2'h3

`define TDCQ_STAT_OST_BIT    0
`define TDCQ_STAT_CBC_BIT    1
`define TDCQ_STAT_RAW_LSB    4
`define TDCQ_STAT_FORCE_LSB  8

`define TDCQ_SYNC_STAGES     3

`endif

// ### logic/tdcq_top.v
// Purpose: Digital compare qualifier ahead of a PWM trip-zone unit.
// Assumes: Trip inputs come asynchronously from comparators and pins; REF_CLK is the PWM clock.
// Notes:   Registers sit on an Avalon-MM slave with one wait state on reads.
//
// Behaviour
// (RULE1) Each compare line source is the OR of the software-selected trip inputs.
// (RULE2) The selected OR result can drive any of the four compare lines.
// (RULE3) Two qualifier units make raw event 0 and raw event 1 per channel.
// (RULE4) 3-bit code: 0 off, 1 low low, 2 low high, 3 high low, 4 high high.
// (RULE5) Code 5 low low high high, 6 low high high low, 7 both high.
// (RULE6) Every raw event passes a window filter before further processing.
// (RULE7) Each filtered event gives a force output and a companion interrupt output.
// (RULE8) A force output can trip through the cycle-by-cycle or one-shot path.
// (RULE9) A force output goes straight to arbitration unless its action is no action; here only the direct action (3) drives ARBITER_DIRECT_TRIP.
// (RULE10) Comparator high and low threshold outputs can feed the A high compare line.
// (RULE11) One-shot trip requests win over simultaneous cycle-by-cycle requests.
// (RULE12) A one-shot trip holds the block until software clears the flag.
// (RULE13) A cycle-by-cycle trip releases at the start of the next PWM period.
// (RULE14) Raw events are registered, so a code change acts from the next cycle.
// (RULE15) Filter passes events when disabled, else blocks them outside the window.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "tdcq_defs.vh"

module tdcq_top #(
    parameter TRIP_W = 8
) (
    input  wire                     REF_CLK,
    input  wire                     RST_N,
    input  wire                     CLK_EN,
    input  wire [TRIP_W-1:0]        TRIP_IN,
    input  wire [`TDCQ_ADDR_W-1:0]  AVS_ADDRESS,
    input  wire                     AVS_READ,
    input  wire                     AVS_WRITE,
    input  wire [31:0]              AVS_WRITEDATA,
    input  wire [3:0]               AVS_BYTEENABLE,
    output reg  [31:0]              AVS_READDATA,
    output wire                     AVS_WAITREQUEST,
    output reg                      COMPARE_A_EVENT0_FORCE,
    output reg                      COMPARE_A_EVENT1_FORCE,
    output reg                      COMPARE_B_EVENT0_FORCE,
    output reg                      COMPARE_B_EVENT1_FORCE,
    output reg  [3:0]               EVENT_IRQ,
    output reg                      ARBITER_DIRECT_TRIP,
    output reg                      ONE_SHOT_TRIP,
    output reg                      CYCLE_BY_CYCLE_TRIP,
    output reg                      OUTPUT_BLOCK,
    output reg                      PERIOD_START
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Qualifier decode shared by all four events.
    //
    // Data flows from the trip pins through a three-stage synchroniser into a
    // per-line selector. The selector ORs the chosen trip inputs onto four
    // compare lines, A high, A low, B high and B low.
    // Each channel pair feeds two qualifier slots, event 0 and event 1. Each slot
    // turns a level combination of its high and low lines into one raw event.
    // The raw events are registered, then gated by an optional window filter.
    // The filtered events become the four force outputs. Each force output also
    // raises a one-cycle interrupt pulse on its rising edge.
    // The action field of each event then routes it to the one-shot path, the
    // cycle-by-cycle path or straight to the trip arbiter. It may also be left
    // without effect.
    // The block has no time base of its own beyond a free-running period counter.
    // That counter serves the window filter, the cycle-by-cycle release and the PERIOD_START output.
    // A full PWM unit would share its counter here. This copy keeps the block
    // self-contained at the cost of one extra 16-bit counter.
    //
    // Code 0 keeps its event low whatever the lines do. Software can therefore
    // park an unused slot without touching the selector.
    // Codes 1 to 4 look at a single line. Codes 5 to 7 look at both lines of
    // the pair, so they detect a band or a crossing.

    function qualify;
        input [2:0] code;
        input       hi;
        input       lo;
        begin
            case (code)
                3'h1:    qualify = ~lo;
                3'h2:    qualify = lo;
                3'h3:    qualify = ~hi;
                3'h4:    qualify = hi;
                3'h5:    qualify = ~lo & hi;
                3'h6:    qualify = lo & ~hi;
                3'h7:    qualify = lo & hi;
                default: qualify = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: a change counts once stages two and three agree.
    //
    // Comparator outputs can chatter for a cycle near their threshold.
    // Requiring two equal samples rejects a one-cycle glitch. The cost is one
    // extra cycle of latency on every trip edge.
    // While the two stages disagree the previous filtered level is held.
    // Only the first stage feeds the second, so no logic reads a stage that
    // may still be metastable.

    reg  [TRIP_W-1:0] sync1_r;
    reg  [TRIP_W-1:0] sync2_r;
    reg  [TRIP_W-1:0] sync3_r;
    reg  [TRIP_W-1:0] trip_r;

    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            sync1_r <= {TRIP_W{1'b0}};
            sync2_r <= {TRIP_W{1'b0}};
            sync3_r <= {TRIP_W{1'b0}};
            trip_r  <= {TRIP_W{1'b0}};
        end else if (CLK_EN) begin
            sync1_r <= TRIP_IN;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            trip_r  <= (sync2_r & sync3_r) | (trip_r & (sync2_r | sync3_r));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Registers.
    //
    // All registers are word addressed. Writes complete with no wait state.
    // Writes take every byte lane except on the clear register, where only
    // lane zero is looked at.
    // Status is read-only and clear is write-only; clear reads back as zero.
    // Addresses outside the map read zero and ignore writes.
    // A low clock enable freezes the bus as well, so a write made while the
    // block is frozen is lost. Software must not access the block then.

    reg  [TRIP_W-1:0] sel_ah_r;
    reg  [TRIP_W-1:0] sel_al_r;
    reg  [TRIP_W-1:0] sel_bh_r;
    reg  [TRIP_W-1:0] sel_bl_r;
    reg  [11:0]       qual_r;
    reg  [7:0]        action_r;
    reg  [3:0]        filt_en_r;
    reg  [15:0]       win_start_r;
    reg  [15:0]       win_end_r;
    reg  [15:0]       period_r;
    reg               ost_flag_r;
    reg               cbc_flag_r;
    reg               rd_pend_r;
    reg  [15:0]       cnt_r;
    reg  [3:0]        raw_r;

    wire wr_en = AVS_WRITE & CLK_EN;
    wire ost_clear = wr_en & (AVS_ADDRESS == `TDCQ_REG_CLEAR) & AVS_BYTEENABLE[0]
                   & AVS_WRITEDATA[`TDCQ_STAT_OST_BIT];

    // Reads take one wait state so that read data comes from a flip-flop.
    assign AVS_WAITREQUEST = AVS_READ & ~rd_pend_r;

    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            sel_ah_r    <= {TRIP_W{1'b0}};
            sel_al_r    <= {TRIP_W{1'b0}};
            sel_bh_r    <= {TRIP_W{1'b0}};
            sel_bl_r    <= {TRIP_W{1'b0}};
            qual_r      <= `TDCQ_QUAL_RESET;
            action_r    <= 8'h00;
            filt_en_r   <= 4'h0;
            win_start_r <= 16'h0000;
            win_end_r   <= 16'h0000;
            period_r    <= `TDCQ_PERIOD_RESET;
        end else if (wr_en) begin
            case (AVS_ADDRESS)
                `TDCQ_REG_SEL_AH: sel_ah_r    <= AVS_WRITEDATA[TRIP_W-1:0]; // see (RULE10)
                `TDCQ_REG_SEL_AL: sel_al_r    <= AVS_WRITEDATA[TRIP_W-1:0];
                `TDCQ_REG_SEL_BH: sel_bh_r    <= AVS_WRITEDATA[TRIP_W-1:0];
                `TDCQ_REG_SEL_BL: sel_bl_r    <= AVS_WRITEDATA[TRIP_W-1:0];
                `TDCQ_REG_QUAL:   qual_r      <= AVS_WRITEDATA[11:0];
                `TDCQ_REG_ACTION: action_r    <= AVS_WRITEDATA[7:0];
                `TDCQ_REG_FILTER: filt_en_r   <= AVS_WRITEDATA[3:0];
                `TDCQ_REG_WINDOW: begin
                    win_start_r <= AVS_WRITEDATA[15:0];
                    win_end_r   <= AVS_WRITEDATA[31:16];
                end
                `TDCQ_REG_PERIOD: period_r    <= AVS_WRITEDATA[15:0];
                default: ;
            endcase
        end
    end

    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            rd_pend_r    <= 1'b0;
            AVS_READDATA <= 32'h00000000;
        end else if (CLK_EN) begin
            rd_pend_r <= AVS_READ & ~rd_pend_r;
            if (AVS_READ & ~rd_pend_r) begin
                case (AVS_ADDRESS)
                    `TDCQ_REG_SEL_AH: AVS_READDATA <= {{(32-TRIP_W){1'b0}}, sel_ah_r};
                    `TDCQ_REG_SEL_AL: AVS_READDATA <= {{(32-TRIP_W){1'b0}}, sel_al_r};
                    `TDCQ_REG_SEL_BH: AVS_READDATA <= {{(32-TRIP_W){1'b0}}, sel_bh_r};
                    `TDCQ_REG_SEL_BL: AVS_READDATA <= {{(32-TRIP_W){1'b0}}, sel_bl_r};
                    `TDCQ_REG_QUAL:   AVS_READDATA <= {20'h00000, qual_r};
                    `TDCQ_REG_ACTION: AVS_READDATA <= {24'h000000, action_r};
                    `TDCQ_REG_FILTER: AVS_READDATA <= {28'h0000000, filt_en_r};
                    `TDCQ_REG_WINDOW: AVS_READDATA <= {win_end_r, win_start_r};
                    `TDCQ_REG_PERIOD: AVS_READDATA <= {16'h0000, period_r};
                    `TDCQ_REG_STATUS: AVS_READDATA <= {20'h00000,
                        COMPARE_B_EVENT1_FORCE, COMPARE_B_EVENT0_FORCE,
                        COMPARE_A_EVENT1_FORCE, COMPARE_A_EVENT0_FORCE,
                        raw_r, 2'h0, cbc_flag_r, ost_flag_r};
                    default:          AVS_READDATA <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Selector, compare lines and qualifiers.
    //
    // A selector bit of one adds that trip input to the OR of its line.
    // A line whose selector is all zero stays low. Codes that test for a low
    // line will then fire at once, which software must keep in mind when it
    // enables a slot before its selector.
    // Both qualifier slots of a channel see the same two lines. Two different
    // conditions on one pair can therefore trip through two different paths.

    wire line_ah = |(trip_r & sel_ah_r); // see (RULE1) see (RULE2) see (RULE10)
    wire line_al = |(trip_r & sel_al_r); // see (RULE1) see (RULE2)
    wire line_bh = |(trip_r & sel_bh_r); // see (RULE2)
    wire line_bl = |(trip_r & sel_bl_r); // see (RULE2)

    // Event order: A0, A1, B0, B1; each holds a 3-bit code in qual_r.
    wire [3:0] raw_nxt = {qualify(qual_r[11:9], line_bh, line_bl), // see (RULE3)
                          qualify(qual_r[8:6],  line_bh, line_bl),
                          qualify(qual_r[5:3],  line_ah, line_al), // see (RULE4) see (RULE5)
                          qualify(qual_r[2:0],  line_ah, line_al)};

    ////////////////////////////////////////////////////////////////////////////////////////////
    // PWM period counter, window filter and event processing.
    //
    // The counter runs from zero to the period value inclusive. One period
    // therefore lasts the period value plus one cycle.
    // The window bounds are inclusive. A window whose start lies above its end,
    // or above the period value, never opens. A filtered event is then blocked
    // for good.
    // The one-shot flag is set by a one-shot request and cleared only by
    // software. A request in the same cycle as a clear wins, so a fault that
    // is still present cannot be cleared away.
    // The cycle-by-cycle flag releases at the period wrap. A request in the
    // wrap cycle keeps it set for the next period.
    // A one-shot request clears the cycle-by-cycle flag, so the one-shot path
    // alone owns the block while both are asked for.

    wire       period_end = (cnt_r >= period_r);
    wire       in_window  = (cnt_r >= win_start_r) & (cnt_r <= win_end_r);
    wire [3:0] filt       = raw_r & (~filt_en_r | {4{in_window}}); // see (RULE6) see (RULE15)

    reg        ost_req;
    reg        cbc_req;
    reg        dir_req;
    integer    i;

    always @* begin
        ost_req = 1'b0;
        cbc_req = 1'b0;
        dir_req = 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
            case (action_r[2*i +: 2])
                `TDCQ_ACT_CBC:    cbc_req = cbc_req | filt[i]; // see (RULE8)
                `TDCQ_ACT_OST:    ost_req = ost_req | filt[i]; // see (RULE8)
                `TDCQ_ACT_DIRECT: dir_req = dir_req | filt[i]; // see (RULE9)
                default: ;
            endcase
        end
    end

    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            cnt_r                  <= 16'h0000;
            raw_r                  <= 4'h0;
            ost_flag_r             <= 1'b0;
            cbc_flag_r             <= 1'b0;
            COMPARE_A_EVENT0_FORCE <= 1'b0;
            COMPARE_A_EVENT1_FORCE <= 1'b0;
            COMPARE_B_EVENT0_FORCE <= 1'b0;
            COMPARE_B_EVENT1_FORCE <= 1'b0;
            EVENT_IRQ              <= 4'h0;
            ARBITER_DIRECT_TRIP    <= 1'b0;
            ONE_SHOT_TRIP          <= 1'b0;
            CYCLE_BY_CYCLE_TRIP    <= 1'b0;
            OUTPUT_BLOCK           <= 1'b0;
            PERIOD_START           <= 1'b0;
        end else if (CLK_EN) begin
            cnt_r        <= period_end ? 16'h0000 : cnt_r + 16'h0001;
            PERIOD_START <= period_end;
            raw_r        <= raw_nxt; // see (RULE14)
            COMPARE_A_EVENT0_FORCE <= filt[0]; // see (RULE7)
            COMPARE_A_EVENT1_FORCE <= filt[1];
            COMPARE_B_EVENT0_FORCE <= filt[2];
            COMPARE_B_EVENT1_FORCE <= filt[3];
            // Interrupt pulses on the rising edge of each filtered event.
            EVENT_IRQ <= filt & ~{COMPARE_B_EVENT1_FORCE, COMPARE_B_EVENT0_FORCE,
                                  COMPARE_A_EVENT1_FORCE, COMPARE_A_EVENT0_FORCE}; // see (RULE7)
            ARBITER_DIRECT_TRIP <= dir_req; // see (RULE9)
            // A new one-shot request beats a clear in the same cycle.
            if (ost_req)
                ost_flag_r <= 1'b1;
            else if (ost_clear)
                ost_flag_r <= 1'b0; // see (RULE12)
            if (ost_req)
                cbc_flag_r <= 1'b0; // see (RULE11)
            else if (cbc_req)
                cbc_flag_r <= 1'b1;
            else if (period_end)
                cbc_flag_r <= 1'b0; // see (RULE13)
            ONE_SHOT_TRIP       <= ost_req; // see (RULE11)
            CYCLE_BY_CYCLE_TRIP <= cbc_req & ~ost_req; // see (RULE11)
            OUTPUT_BLOCK <= ost_req | (ost_flag_r & ~ost_clear) | cbc_req
                          | (cbc_flag_r & ~period_end); // see (RULE12) see (RULE13)
        end
    end

endmodule

// ### sim/tb_tdcq_top.sv
// Purpose: Self-checking bench for the compare qualifier.
// Assumes: Bit 0 and bit 2 feed the high lines, bit 1 the low lines.
// Notes:   Period shortened to 16 cycles so trip releases come quickly.
`timescale 1ns/1ps
`include "tdcq_defs.vh"
module tb_tdcq_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        rd = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  ad = 4'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] q;
    logic [7:0]  lvl = 8'h00;
    wire  [7:0]  trip;
    wire  [31:0] rdata;
    wire  [3:0]  frc, irq;
    wire         wq, arb, one_shot_trip, cbc, blk, pst;
    int          err_count = 0;
    int          check_count = 0;
    // Expected force per code, indexed by {high line, low line}.
    logic [3:0]  tab [8] = '{4'h0, 4'h5, 4'hA, 4'h3, 4'hC, 4'h4, 4'h2, 4'h8};

    always #50 clk = ~clk;

    tdcq_trip_src tdcq_trip_src_inst (.clk(clk), .lvl(lvl), .trip(trip));
    tdcq_top tdcq_top_inst (
        .REF_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .TRIP_IN(trip),
        .AVS_ADDRESS(ad), .AVS_READ(rd), .AVS_WRITE(we), .AVS_WRITEDATA(wd),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq),
        .COMPARE_A_EVENT0_FORCE(frc[0]), .COMPARE_A_EVENT1_FORCE(frc[1]),
        .COMPARE_B_EVENT0_FORCE(frc[2]), .COMPARE_B_EVENT1_FORCE(frc[3]),
        .EVENT_IRQ(irq), .ARBITER_DIRECT_TRIP(arb), .ONE_SHOT_TRIP(one_shot_trip),
        .CYCLE_BY_CYCLE_TRIP(cbc), .OUTPUT_BLOCK(blk), .PERIOD_START(pst)
    );
    ////////////////////////////////////////
    task test_done;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Request is held until waitrequest is seen low at a rising edge.
    task bus(input logic r, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        ad <= a;
        wd <= d;
        rd <= r;
        we <= !r;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wq && n < 20);
        chk({31'h0, wq}, 32'h0);
        if (wq) begin
            test_done;
        end
        q = rdata;
        rd <= 1'b0;
        we <= 1'b0;
    endtask

    task settle;
        repeat (10) @(posedge clk);
    endtask

    initial begin
        int c, k;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        bus(1, `TDCQ_REG_PERIOD, 0);
        chk(q, 32'h3E7);
        bus(0, `TDCQ_REG_PERIOD, 32'hF);
        bus(1, 4'hF, 0);
        chk(q, 32'h0);
        bus(1, `TDCQ_REG_CLEAR, 0);
        chk(q, 32'h0);
        $display("reset and map test done");
        for (c = 0; c < 4; c++) bus(0, c[3:0], (c % 2) ? 32'h2 : 32'h5);
        for (c = 0; c < 8; c++) begin
            bus(0, `TDCQ_REG_QUAL, {20'h0, {4{c[2:0]}}});
            for (k = 0; k < 4; k++) begin
                lvl <= {6'h00, k[0], k[1]};
                settle;
                chk({blk, arb, one_shot_trip, cbc, frc}, {4'h0, {4{tab[c][k]}}});
            end
        end
        $display("qualifier table test done");
        bus(0, `TDCQ_REG_QUAL, 32'h924);
        lvl <= 8'h04;
        settle;
        chk(frc, 4'hF);
        bus(0, `TDCQ_REG_WINDOW, 32'h001E0014);
        bus(0, `TDCQ_REG_FILTER, 32'h1);
        settle;
        chk(frc, 4'hE);
        bus(0, `TDCQ_REG_FILTER, 32'h0);
        bus(0, `TDCQ_REG_ACTION, 32'h2);
        settle;
        chk({blk, one_shot_trip, cbc}, 3'h6);
        lvl <= 8'h00;
        repeat (40) @(posedge clk);
        chk({blk, one_shot_trip}, 2'h2);
        bus(0, `TDCQ_REG_CLEAR, 32'h1);
        settle;
        chk(blk, 1'b0);
        bus(0, `TDCQ_REG_ACTION, 32'h1);
        lvl <= 8'h04;
        settle;
        chk({blk, one_shot_trip, cbc}, 3'h5);
        lvl <= 8'h00;
        repeat (40) @(posedge clk);
        chk(blk, 1'b0);
        $display("trip path test done");
        bus(0, `TDCQ_REG_ACTION, 32'h6);
        lvl <= 8'h04;
        settle;
        chk({one_shot_trip, cbc}, 2'h2);
        lvl <= 8'h00;
        settle;
        bus(0, `TDCQ_REG_CLEAR, 32'h1);
        bus(0, `TDCQ_REG_ACTION, 32'hFF);
        lvl <= 8'h04;
        settle;
        chk({arb, one_shot_trip, cbc}, 3'h4);
        bus(0, `TDCQ_REG_ACTION, 32'h0);
        settle;
        chk({arb, frc}, 5'h0F);
        bus(1, `TDCQ_REG_STATUS, 0);
        chk(q[11:8], 4'hF);
        $display("action test done");
        // A write while the clock enable is low must be lost.
        clk_en <= 1'b0;
        bus(0, `TDCQ_REG_PERIOD, 32'h7);
        clk_en <= 1'b1;
        bus(1, `TDCQ_REG_PERIOD, 0);
        chk(q, 32'hF);
        // A reset in mid-run clears a standing block and the registers.
        bus(0, `TDCQ_REG_ACTION, 32'h2);
        settle;
        chk(blk, 1'b1);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        chk({blk, arb, one_shot_trip, cbc, frc, irq, pst}, 13'h0000);
        bus(1, `TDCQ_REG_PERIOD, 0);
        chk(q, 32'h3E7);
        settle;
        chk({blk, frc}, 5'h00);
        $display("freeze and reset test done");
        test_done;
    end
endmodule

bind tdcq_top tdcq_asserts tdcq_asserts_inst (.REF_CLK, .RST_N, .AVS_READ, .AVS_WRITE,
    .AVS_WAITREQUEST, .AVS_READDATA, .COMPARE_A_EVENT0_FORCE, .COMPARE_A_EVENT1_FORCE,
    .COMPARE_B_EVENT0_FORCE, .COMPARE_B_EVENT1_FORCE, .EVENT_IRQ, .ARBITER_DIRECT_TRIP,
    .ONE_SHOT_TRIP, .CYCLE_BY_CYCLE_TRIP, .OUTPUT_BLOCK, .PERIOD_START);

// ### sim/tdcq_asserts.sv
// Purpose: Port-level properties of the compare qualifier.
// Assumes: CLK_EN dropped only around a single write.
// Notes:   Bound from the testbench top.
`timescale 1ns/1ps
module tdcq_asserts (
    input wire        REF_CLK,
    input wire        RST_N,
    input wire        AVS_READ,
    input wire        AVS_WRITE,
    input wire        AVS_WAITREQUEST,
    input wire [31:0] AVS_READDATA,
    input wire        COMPARE_A_EVENT0_FORCE,
    input wire        COMPARE_A_EVENT1_FORCE,
    input wire        COMPARE_B_EVENT0_FORCE,
    input wire        COMPARE_B_EVENT1_FORCE,
    input wire [3:0]  EVENT_IRQ,
    input wire        ARBITER_DIRECT_TRIP,
    input wire        ONE_SHOT_TRIP,
    input wire        CYCLE_BY_CYCLE_TRIP,
    input wire        OUTPUT_BLOCK,
    input wire        PERIOD_START
);
    ////////////////////////////////////////
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    wire any_f = COMPARE_A_EVENT0_FORCE | COMPARE_A_EVENT1_FORCE |
                 COMPARE_B_EVENT0_FORCE | COMPARE_B_EVENT1_FORCE;

    chk_read_wait: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (AVS_WRITE |-> !AVS_WAITREQUEST)
        else $error("write stalled");
    chk_rdata_hold: assert property (!$past(AVS_READ) |-> $stable(AVS_READDATA))
        else $error("read data moved without a read");
    chk_irq_rise: assert property ($rose(COMPARE_A_EVENT0_FORCE) |-> ##[0:1] EVENT_IRQ[0])
        else $error("no interrupt on force rise");
    chk_irq_pulse: assert property (EVENT_IRQ[0] |=> !EVENT_IRQ[0])
        else $error("interrupt longer than one cycle");
    chk_cbc_prio: assert property (CYCLE_BY_CYCLE_TRIP |-> !ONE_SHOT_TRIP)
        else $error("cycle trip beside one-shot trip");
    chk_ost_block: assert property (ONE_SHOT_TRIP |-> ##[0:2] OUTPUT_BLOCK)
        else $error("one-shot trip did not block");
    chk_ost_src: assert property (ONE_SHOT_TRIP |-> any_f || $past(any_f))
        else $error("one-shot trip without event");
    chk_direct_src: assert property (ARBITER_DIRECT_TRIP |-> any_f || $past(any_f))
        else $error("direct trip without event");
    chk_block_rel: assert property ($fell(OUTPUT_BLOCK) |-> PERIOD_START ||
        $past(PERIOD_START) || $past(PERIOD_START, 2) || $past(AVS_WRITE) || $past(AVS_WRITE, 2))
        else $error("block released without cause");
endmodule

// ### sim/tdcq_trip_src.sv
// Purpose: Comparator and trip pin levels on the far side.
// Assumes: Levels are set by the bench.
// Notes:   One register of skew, like an unsynchronised comparator.
`timescale 1ns/1ps
module tdcq_trip_src (
    input wire         clk,
    input wire  [7:0]  lvl,
    output logic [7:0] trip
);
    always @(posedge clk) begin
        trip <= lvl;
    end
endmodule
